// ===== core/pusc_power_up_state_control.sv
// power-up and operating-state control for the programmable logic device
// assumes supply-good and pattern-valid inputs synchronous to REF_CLK
// What this block does
// - while the core supply is below its safe level the device stays quiescent.
// - quiescent means pins and test access disabled, outputs off, pull-ups on.
// - after supply-good every user register is initialised within the init time.
// - once initialisation ends the device enters its operating state at once.
// - with no user pattern outputs stay disabled and pull-ups stay on.
// - when erased the test-access controller and its pins are enabled.
// - with a pattern the user pins act as configured and pull-ups are off.
// - when programmed the test-access controller stays enabled.
// - inputs, clocks and logic blocks run only in valid user operation.
`timescale 1ns/100ps
`default_nettype none
module pusc_power_up_state_control
  import pusc_pkg::*;
#(
  parameter logic [`PUSC_CNT_W-1:0] INIT_CYCLES = `PUSC_INIT_CYCLES
) (
  // clock and reset
  input  wire logic REF_CLK,
  input  wire logic RST_N,
  // supply monitor and non-volatile pattern state
  input  wire logic CORE_SUPPLY_GOOD,
  input  wire logic PATTERN_VALID,
  // controls toward pin_io_cell and boundary scan
  output var  logic PULLUP_EN,
  output var  logic USER_OUT_EN,
  output var  logic USER_IN_EN,
  output var  logic LOGIC_EN,
  output var  logic JTAG_EN,
  output var  logic USER_REG_INIT,
  output var  logic STATE_READY
);
  import pusc_pkg::*;

  // sequencing state and init counter
  pusc_state_t             state;
  pusc_state_t             next_state;
  logic [`PUSC_CNT_W-1:0]  count;
  logic [`PUSC_CNT_W-1:0]  next_count;
  logic                    init_done;

  // stored-pattern decision, frozen for one supply cycle
  logic                    programmed;
  logic                    next_programmed;

  // next values of the registered controls
  logic                    next_pullup_en;
  logic                    next_user_out_en;
  logic                    next_user_in_en;
  logic                    next_logic_en;
  logic                    next_jtag_en;
  logic                    next_user_reg_init;
  logic                    next_state_ready;

  // terminal count; the counter starts from zero on entry to init
  assign init_done = (count >= INIT_CYCLES - 1'b1);

  // sequencing: quiet, init, then one of the two operating states
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      PUSC_QUIET: begin
        next_count = '0;
        if (CORE_SUPPLY_GOOD) begin
          next_state = PUSC_INIT;
        end
      end
      PUSC_INIT: begin
        next_count = count + 1'b1;
        if (init_done) begin
          next_state = programmed ? PUSC_USER : PUSC_ERASED;
          next_count = '0;
        end
      end
      PUSC_USER: begin
        next_count = '0;
      end
      PUSC_ERASED: begin
        next_count = '0;
      end
      default: begin
        next_state = PUSC_QUIET;
        next_count = '0;
      end
    endcase
    // supply loss drops straight back to quiescent from any state
    if (!CORE_SUPPLY_GOOD) begin
      next_state = PUSC_QUIET;
      next_count = '0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state <= PUSC_QUIET;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // flag taken only on the quiet-to-init step; a later change of the
  // stored pattern waits for the next supply cycle, so the mode cannot
  // flip under a running design
  always_comb begin
    next_programmed = programmed;
    if (state == PUSC_QUIET && CORE_SUPPLY_GOOD) begin
      next_programmed = PATTERN_VALID;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      programmed <= 1'b0;
    end else begin
      programmed <= next_programmed;
    end
  end

  // outputs decoded from the next state so each port is a plain flop
  // and follows the state with no extra cycle of lag
  always_comb begin
    next_pullup_en     = 1'b1;
    next_user_out_en   = 1'b0;
    next_user_in_en    = 1'b0;
    next_logic_en      = 1'b0;
    next_jtag_en       = 1'b0;
    next_user_reg_init = 1'b0;
    next_state_ready   = 1'b0;
    case (next_state)
      PUSC_QUIET: begin
        next_pullup_en     = 1'b1;
        next_user_out_en   = 1'b0;
        next_user_in_en    = 1'b0;
        next_logic_en      = 1'b0;
        next_jtag_en       = 1'b0;
        next_user_reg_init = 1'b0;
        next_state_ready   = 1'b0;
      end
      PUSC_INIT: begin
        next_pullup_en     = 1'b1;
        next_user_out_en   = 1'b0;
        next_user_in_en    = 1'b0;
        next_logic_en      = 1'b0;
        next_jtag_en       = 1'b0;
        next_user_reg_init = 1'b1;
        next_state_ready   = 1'b0;
      end
      PUSC_ERASED: begin
        next_pullup_en     = 1'b1;
        next_user_out_en   = 1'b0;
        next_user_in_en    = 1'b0;
        next_logic_en      = 1'b0;
        next_jtag_en       = 1'b1;
        next_user_reg_init = 1'b0;
        next_state_ready   = 1'b1;
      end
      PUSC_USER: begin
        next_pullup_en     = 1'b0;
        next_user_out_en   = 1'b1;
        next_user_in_en    = 1'b1;
        next_logic_en      = 1'b1;
        next_jtag_en       = 1'b1;
        next_user_reg_init = 1'b0;
        next_state_ready   = 1'b1;
      end
      default: begin
        next_pullup_en     = 1'b1;
        next_user_out_en   = 1'b0;
        next_user_in_en    = 1'b0;
        next_logic_en      = 1'b0;
        next_jtag_en       = 1'b0;
        next_user_reg_init = 1'b0;
        next_state_ready   = 1'b0;
      end
    endcase
  end

  // reset values match the quiescent row: pull-ups on, all else off
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      PULLUP_EN     <= 1'b1;
      USER_OUT_EN   <= 1'b0;
      USER_IN_EN    <= 1'b0;
      LOGIC_EN      <= 1'b0;
      JTAG_EN       <= 1'b0;
      USER_REG_INIT <= 1'b0;
      STATE_READY   <= 1'b0;
    end else begin
      PULLUP_EN     <= next_pullup_en;
      USER_OUT_EN   <= next_user_out_en;
      USER_IN_EN    <= next_user_in_en;
      LOGIC_EN      <= next_logic_en;
      JTAG_EN       <= next_jtag_en;
      USER_REG_INIT <= next_user_reg_init;
      STATE_READY   <= next_state_ready;
    end
  end

  // limitation: one init length serves every part size; a larger part
  // needs its own INIT_CYCLES at the instance
endmodule
`default_nettype wire

// ===== core/pusc_cfg.svh
// power-up state control: timing counts and state encodings
// assumes a 125 MHz REF_CLK; included by bare name
`ifndef PUSC_CFG_SVH
`define PUSC_CFG_SVH
`define PUSC_CLK_MHZ       125
`define PUSC_INIT_TIME_US  100
// sized to the counter so the parameter default carries no spare bits
`define PUSC_INIT_CYCLES   (24'(`PUSC_INIT_TIME_US * `PUSC_CLK_MHZ))
`define PUSC_CNT_W         24
`define PUSC_ST_QUIET      2'b00
`define PUSC_ST_INIT       2'b01
`define PUSC_ST_USER       2'b11
`define PUSC_ST_ERASED     2'b10
`endif

// ===== core/pusc_pkg.sv
// power-up state control: shared types
// assumes pusc_cfg.svh is on the include path
`include "pusc_cfg.svh"
package pusc_pkg;
  typedef enum logic [1:0] {
    PUSC_QUIET  = `PUSC_ST_QUIET,
    PUSC_INIT   = `PUSC_ST_INIT,
    PUSC_USER   = `PUSC_ST_USER,
    PUSC_ERASED = `PUSC_ST_ERASED
  } pusc_state_t;
endpackage

// ===== tb/pusc_assertions.sv
// checker on the power-up state control ports
// assumes a bind from the bench
`timescale 1ns/100ps
`default_nettype none
module pusc_assertions #(parameter int INIT_CYCLES = 8) (
  input wire logic REF_CLK, RST_N, CORE_SUPPLY_GOOD, PATTERN_VALID,
  input wire logic PULLUP_EN, USER_OUT_EN, USER_IN_EN, LOGIC_EN,
  input wire logic JTAG_EN, USER_REG_INIT, STATE_READY
);
  int n;
  logic p;
  wire logic quiet = !USER_REG_INIT && !STATE_READY;
  // p mirrors the pattern flag taken on the last quiet edge
  always_ff @(posedge REF_CLK) begin
    n <= (RST_N && USER_REG_INIT) ? n + 1 : 0;
    p <= quiet ? PATTERN_VALID : p;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  quiet_pins_a: assert property (quiet |-> PULLUP_EN && !USER_OUT_EN && !USER_IN_EN && !LOGIC_EN && !JTAG_EN)
    else $error("quiet outputs wrong");
  supply_loss_a: assert property (!CORE_SUPPLY_GOOD |=> quiet) else $error("no quiet on supply loss");
  init_start_a: assert property (quiet && CORE_SUPPLY_GOOD |=> USER_REG_INIT) else $error("init not started");
  init_cap_a: assert property (USER_REG_INIT |-> n < INIT_CYCLES) else $error("init too long");
  ready_now_a: assert property ($fell(USER_REG_INIT) && $past(CORE_SUPPLY_GOOD) |-> STATE_READY && n == INIT_CYCLES)
    else $error("ready not at init end");
  erased_mode_a: assert property (STATE_READY && !USER_OUT_EN |-> PULLUP_EN && JTAG_EN && !USER_IN_EN && !LOGIC_EN)
    else $error("erased outputs wrong");
  user_mode_a: assert property (STATE_READY && USER_OUT_EN |-> !PULLUP_EN && JTAG_EN && USER_IN_EN && LOGIC_EN)
    else $error("user outputs wrong");
  mode_pick_a: assert property ($rose(STATE_READY) |-> USER_OUT_EN == p) else $error("wrong mode");
  mode_hold_a: assert property (STATE_READY && $past(STATE_READY) |-> $stable(USER_OUT_EN)) else $error("mode moved");
endmodule
`default_nettype wire

// ===== tb/pusc_supply_model.sv
// supply monitor and stored pattern flag
// assumes the bench moves up and pat off the falling edge
`timescale 1ns/100ps
`default_nettype none
module pusc_supply_model (
  input  wire logic clk,
  input  wire logic up,
  input  wire logic pat,
  output var  logic good,
  output var  logic valid
);
  logic [1:0] q = 2'b00;
  // one cycle of monitor lag, outputs move at the falling edge
  always @(posedge clk) q <= {up, pat};
  always @(negedge clk) {good, valid} <= q;
  initial {good, valid} = 2'b00;
endmodule
`default_nettype wire

// ===== tb/pusc_power_up_state_control_tb.sv
// bench for power-up state control: erased and programmed runs
// assumes the supply model in front and an 8-cycle init
`timescale 1ns/100ps
`default_nettype none
module pusc_power_up_state_control_tb;
  localparam int IC = 8;
  logic clk = 0, rst_n = 0, up = 0, pat = 0, good, valid, pu, uo, ui, le, je, ri, sr;
  int miscompares = 0, comparisons = 0, n;
  logic [5:0] rows [2] = '{6'b0_10001, 6'b1_01111};
  wire logic [4:0] outs = {pu, uo, ui, le, je};
  initial forever #4 clk = ~clk;
  pusc_supply_model sm (.clk(clk), .up(up), .pat(pat), .good(good), .valid(valid));
  pusc_power_up_state_control #(.INIT_CYCLES(24'(IC))) uut (.REF_CLK(clk), .RST_N(rst_n),
    .CORE_SUPPLY_GOOD(good), .PATTERN_VALID(valid), .PULLUP_EN(pu), .USER_OUT_EN(uo),
    .USER_IN_EN(ui), .LOGIC_EN(le), .JTAG_EN(je), .USER_REG_INIT(ri), .STATE_READY(sr));
  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: output mismatch", $time);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // drop supply, then bring it up and count edges until ready
  task power(input logic p);
    cyc(1);
    up <= 0;
    cyc(3);
    chk(outs === 5'b10000 && ri === 1'b0);
    pat <= p;
    up <= 1;
    n = 0;
    for (int k = 0; k < 40 && sr !== 1'b1; k++) begin
      @(posedge clk);
      #1 n += good;
    end
    if (sr !== 1'b1) begin
      miscompares++;
      wrap_up;
    end
  endtask
  initial begin
    cyc(6);
    rst_n <= 1;
    for (int i = 0; i < 2; i++) begin
      power(rows[i][5]);
      chk(n == IC + 1 && ri === 1'b0);
      chk(outs === rows[i][4:0]);
      $display("row %0d done", i);
    end
    pat <= 0;
    cyc(4);
    chk(outs === 5'b01111);
    up <= 0;
    cyc(3);
    up <= 1;
    cyc(6);
    chk(ri === 1'b1);
    up <= 0;
    cyc(3);
    chk(outs === 5'b10000 && ri === 1'b0);
    $display("drop test done");
    power(1);
    rst_n <= 0;
    cyc(2);
    chk(outs === 5'b10000 && sr === 1'b0);
    rst_n <= 1;
    cyc(2);
    chk(ri === 1'b1 && sr === 1'b0);
    $display("reset test done");
    wrap_up;
  end
endmodule
bind pusc_power_up_state_control pusc_assertions #(.INIT_CYCLES(INIT_CYCLES)) chk_i (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .CORE_SUPPLY_GOOD(CORE_SUPPLY_GOOD), .PATTERN_VALID(PATTERN_VALID), .PULLUP_EN(PULLUP_EN),
  .USER_OUT_EN(USER_OUT_EN), .USER_IN_EN(USER_IN_EN), .LOGIC_EN(LOGIC_EN), .JTAG_EN(JTAG_EN),
  .USER_REG_INIT(USER_REG_INIT), .STATE_READY(STATE_READY));
`default_nettype wire
